// ===== src/core_sfr_pkg.sv
// constants, types and field layout of the core special-function registers

package core_sfr_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 12;
  localparam logic [7:0]  IDX_SP      = 8'h81;
  localparam logic [7:0]  IDX_DPL     = 8'h82;
  localparam logic [7:0]  IDX_DPH     = 8'h83;
  localparam logic [7:0]  IDX_PSW     = 8'hd0;
  localparam logic [7:0]  IDX_ACC     = 8'he0;
  localparam logic [7:0]  IDX_AUX     = 8'hf0;
  localparam logic [1:0]  BYTE_SHIFT  = 2'h2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_SP      = 8'h07;
  localparam logic [7:0]  RST_ZERO    = 8'h00;

  // ----------------------------------------------------------------
  // status word bit positions
  // ----------------------------------------------------------------
  localparam int unsigned PSW_CY      = 7;
  localparam int unsigned PSW_AC      = 6;
  localparam int unsigned PSW_F0      = 5;
  localparam int unsigned PSW_RS1     = 4;
  localparam int unsigned PSW_RS0     = 3;
  localparam int unsigned PSW_OV      = 2;
  localparam int unsigned PSW_F1      = 1;
  localparam int unsigned PSW_P       = 0;

  // ----------------------------------------------------------------
  // arithmetic constants and bus answers
  // ----------------------------------------------------------------
  localparam logic [3:0]  BCD_MAX     = 4'h9;
  localparam logic [7:0]  BCD_LO_ADJ  = 8'h06;
  localparam logic [7:0]  BCD_HI_ADJ  = 8'h60;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // operations the instruction datapath may request
  typedef enum logic [3:0] {
    OP_ADD,
    OP_ADD_CARRY_OP,
    OP_SUBTRACT_BORROW_OP,
    OP_MUL,
    OP_DIV,
    OP_DA,
    OP_COMPARE_JUMP_NE_OP,
    OP_PUSH,
    OP_POP
  } core_op_e;

endpackage

// ===== src/cpu_core_sfr_file.sv
// core special-function register file with AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none

module cpu_core_sfr_file (
  // clock and reset
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  // axi4-lite write address and data
  input  wire logic [core_sfr_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [31:0]                       wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  // axi4-lite write response
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  // axi4-lite read
  input  wire logic [core_sfr_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [31:0]                            rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready,
  // instruction datapath requests
  input  wire logic                              op_valid,
  input  wire core_sfr_pkg::core_op_e            op_code,
  input  wire logic [7:0]                        op_src,
  input  wire logic [7:0]                        op_cmp_a,
  input  wire logic [7:0]                        stack_push_data,
  // scratch-pad stack access
  output logic                                   stack_wr_en,
  output logic                                   stack_rd_en,
  output logic [7:0]                             stack_addr,
  output logic [7:0]                             stack_wr_data,
  // register contents for the core
  output logic [7:0]                             arith_primary_reg,
  output logic [7:0]                             mul_div_aux_reg,
  output logic [7:0]                             stack_top_pointer_reg,
  output logic [15:0]                            data_ptr_16,
  output logic [7:0]                             program_status_word,
  output logic [4:0]                             bank_base_addr
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] data_ptr_low_reg;
  logic [7:0] data_ptr_high_reg;
  logic       carry_flag;
  logic       nibble_carry_flag;
  logic       user_flag_zero;
  logic       bank_sel_hi;
  logic       bank_sel_lo;
  logic       signed_overflow_flag;
  logic       user_flag_one;
  logic       odd_ones_flag;

  // ----------------------------------------------------------------
  // axi4-lite write side
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_LOCAL = core_sfr_pkg::ADDR_W;

  logic                    aw_held;
  logic                    w_held;
  logic [ADDR_LOCAL-1:0]   aw_addr_q;
  logic [7:0]              w_data_q;
  logic                    w_lane_q;
  logic                    wr_fire;
  logic                    wr_hit;
  logic [7:0]              wr_idx;

  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_idx  = aw_addr_q[9:2];
  assign wr_hit  = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q[11:10] == 2'h0)
                   && (wr_idx == core_sfr_pkg::IDX_SP
                    || wr_idx == core_sfr_pkg::IDX_DPL
                    || wr_idx == core_sfr_pkg::IDX_DPH
                    || wr_idx == core_sfr_pkg::IDX_PSW
                    || wr_idx == core_sfr_pkg::IDX_ACC
                    || wr_idx == core_sfr_pkg::IDX_AUX);

  // address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 8'h00;
      w_lane_q  <= 1'b0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        w_data_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= core_sfr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? core_sfr_pkg::RESP_OKAY : core_sfr_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // only the low byte lane carries register data
  logic sw_we;
  assign sw_we = wr_fire && wr_hit && w_lane_q;

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  logic [7:0]  next_acc;
  logic [7:0]  next_aux;
  logic        upd_acc;
  logic        upd_aux;
  logic        upd_cy;
  logic        upd_ac;
  logic        upd_ov;
  logic        next_cy;
  logic        next_ac;
  logic        next_ov;
  logic [7:0]  add_b;
  logic        add_cin;
  logic [8:0]  sum9;
  logic [4:0]  sum_lo;
  logic [7:0]  sum_b6;
  logic [15:0] prod;
  logic [7:0]  da_step;
  logic [8:0]  da_sum;
  logic        is_sub;

  always_comb begin
    is_sub  = (op_code == core_sfr_pkg::OP_SUBTRACT_BORROW_OP);
    // subtraction runs through the adder as a + ~b + ~borrow
    add_b   = is_sub ? ~op_src : op_src;
    add_cin = is_sub ? ~carry_flag
                     : (op_code == core_sfr_pkg::OP_ADD_CARRY_OP) && carry_flag;
    sum9    = {1'b0, arith_primary_reg} + {1'b0, add_b} + {8'h00, add_cin};
    sum_lo  = {1'b0, arith_primary_reg[3:0]} + {1'b0, add_b[3:0]}
              + {4'h0, add_cin};
    sum_b6  = {1'b0, arith_primary_reg[6:0]} + {1'b0, add_b[6:0]}
              + {7'h00, add_cin};
    prod    = arith_primary_reg * mul_div_aux_reg;
    da_step = ((arith_primary_reg[3:0] > core_sfr_pkg::BCD_MAX)
               || nibble_carry_flag) ? core_sfr_pkg::BCD_LO_ADJ : 8'h00;
    da_sum  = {1'b0, arith_primary_reg} + {1'b0, da_step};
    next_acc = arith_primary_reg;
    next_aux = mul_div_aux_reg;
    next_cy  = carry_flag;
    next_ac  = nibble_carry_flag;
    next_ov  = signed_overflow_flag;
    upd_acc  = 1'b0;
    upd_aux  = 1'b0;
    upd_cy   = 1'b0;
    upd_ac   = 1'b0;
    upd_ov   = 1'b0;
    if (op_valid) begin
      unique case (op_code)
        core_sfr_pkg::OP_ADD, core_sfr_pkg::OP_ADD_CARRY_OP,
        core_sfr_pkg::OP_SUBTRACT_BORROW_OP: begin
          upd_acc  = 1'b1;
          upd_cy   = 1'b1;
          upd_ac   = 1'b1;
          upd_ov   = 1'b1;
          next_acc = sum9[7:0];
          next_cy  = sum9[8] ^ is_sub;
          next_ac  = sum_lo[4] ^ is_sub;
          next_ov  = sum9[8] ^ sum_b6[7];
        end
        core_sfr_pkg::OP_MUL: begin
          upd_acc  = 1'b1;
          upd_aux  = 1'b1;
          upd_cy   = 1'b1;
          upd_ov   = 1'b1;
          next_acc = prod[7:0];
          next_aux = prod[15:8];
          next_cy  = 1'b0;
          next_ov  = |prod[15:8];
        end
        core_sfr_pkg::OP_DIV: begin
          upd_cy  = 1'b1;
          upd_ov  = 1'b1;
          next_cy = 1'b0;
          next_ov = (mul_div_aux_reg == 8'h00);
          if (mul_div_aux_reg != 8'h00) begin
            upd_acc  = 1'b1;
            upd_aux  = 1'b1;
            next_acc = arith_primary_reg / mul_div_aux_reg;
            next_aux = arith_primary_reg % mul_div_aux_reg;
          end
        end
        core_sfr_pkg::OP_DA: begin
          upd_acc = 1'b1;
          upd_cy  = 1'b1;
          next_cy = carry_flag || da_sum[8]
                    || (da_sum[7:4] > core_sfr_pkg::BCD_MAX);
          next_acc = next_cy ? da_sum[7:0] + core_sfr_pkg::BCD_HI_ADJ
                             : da_sum[7:0];
        end
        core_sfr_pkg::OP_COMPARE_JUMP_NE_OP: begin
          upd_cy  = 1'b1;
          next_cy = op_cmp_a < op_src;
        end
        core_sfr_pkg::OP_PUSH, core_sfr_pkg::OP_POP: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers: instruction updates override a same-cycle bus write
  // ----------------------------------------------------------------
  // primary arithmetic register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arith_primary_reg <= core_sfr_pkg::RST_ZERO;
    end else if (upd_acc) begin
      arith_primary_reg <= next_acc;
    end else if (sw_we && wr_idx == core_sfr_pkg::IDX_ACC) begin
      arith_primary_reg <= w_data_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mul_div_aux_reg <= core_sfr_pkg::RST_ZERO;
    end else if (upd_aux) begin
      mul_div_aux_reg <= next_aux;
    end else if (sw_we && wr_idx == core_sfr_pkg::IDX_AUX) begin
      mul_div_aux_reg <= w_data_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_ptr_low_reg  <= core_sfr_pkg::RST_ZERO;
      data_ptr_high_reg <= core_sfr_pkg::RST_ZERO;
    end else if (sw_we) begin
      if (wr_idx == core_sfr_pkg::IDX_DPL) begin
        data_ptr_low_reg <= w_data_q;
      end
      if (wr_idx == core_sfr_pkg::IDX_DPH) begin
        data_ptr_high_reg <= w_data_q;
      end
    end
  end
  assign data_ptr_16 = {data_ptr_high_reg, data_ptr_low_reg};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_top_pointer_reg <= core_sfr_pkg::RST_SP;
      stack_wr_en           <= 1'b0;
      stack_rd_en           <= 1'b0;
      stack_addr            <= core_sfr_pkg::RST_ZERO;
      stack_wr_data         <= core_sfr_pkg::RST_ZERO;
    end else begin
      stack_wr_en <= op_valid && op_code == core_sfr_pkg::OP_PUSH;
      stack_rd_en <= op_valid && op_code == core_sfr_pkg::OP_POP;
      if (op_valid && op_code == core_sfr_pkg::OP_PUSH) begin
        stack_top_pointer_reg <= stack_top_pointer_reg + 8'h01;
        stack_addr            <= stack_top_pointer_reg + 8'h01;
        stack_wr_data         <= stack_push_data;
      end else if (op_valid && op_code == core_sfr_pkg::OP_POP) begin
        stack_top_pointer_reg <= stack_top_pointer_reg - 8'h01;
        stack_addr            <= stack_top_pointer_reg;
      end else if (sw_we && wr_idx == core_sfr_pkg::IDX_SP) begin
        stack_top_pointer_reg <= w_data_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_flag           <= 1'b0;
      nibble_carry_flag    <= 1'b0;
      user_flag_zero       <= 1'b0;
      bank_sel_hi          <= 1'b0;
      bank_sel_lo          <= 1'b0;
      signed_overflow_flag <= 1'b0;
      user_flag_one        <= 1'b0;
    end else begin
      if (sw_we && wr_idx == core_sfr_pkg::IDX_PSW) begin
        carry_flag           <= w_data_q[core_sfr_pkg::PSW_CY];
        nibble_carry_flag    <= w_data_q[core_sfr_pkg::PSW_AC];
        user_flag_zero       <= w_data_q[core_sfr_pkg::PSW_F0];
        bank_sel_hi          <= w_data_q[core_sfr_pkg::PSW_RS1];
        bank_sel_lo          <= w_data_q[core_sfr_pkg::PSW_RS0];
        signed_overflow_flag <= w_data_q[core_sfr_pkg::PSW_OV];
        user_flag_one        <= w_data_q[core_sfr_pkg::PSW_F1];
      end
      if (upd_cy) begin
        carry_flag <= next_cy;
      end
      if (upd_ac) begin
        nibble_carry_flag <= next_ac;
      end
      if (upd_ov) begin
        signed_overflow_flag <= next_ov;
      end
    end
  end

  // parity follows the register, never stored
  assign odd_ones_flag = ^arith_primary_reg;

  assign bank_base_addr = {bank_sel_hi, bank_sel_lo, 3'h0};

  assign program_status_word = {carry_flag, nibble_carry_flag,
                                user_flag_zero, bank_sel_hi, bank_sel_lo,
                                signed_overflow_flag, user_flag_one,
                                odd_ones_flag};

  // ----------------------------------------------------------------
  // axi4-lite read side
  // ----------------------------------------------------------------
  logic [7:0] rd_idx;
  logic       rd_ok;
  logic [7:0] rd_byte;

  assign arready = !rvalid;
  assign rd_idx  = araddr[9:2];

  always_comb begin
    rd_ok   = (araddr[1:0] == 2'h0) && (araddr[11:10] == 2'h0);
    rd_byte = 8'h00;
    unique case (rd_idx)
      core_sfr_pkg::IDX_SP:  rd_byte = stack_top_pointer_reg;
      core_sfr_pkg::IDX_DPL: rd_byte = data_ptr_low_reg;
      core_sfr_pkg::IDX_DPH: rd_byte = data_ptr_high_reg;
      core_sfr_pkg::IDX_PSW: rd_byte = program_status_word;
      core_sfr_pkg::IDX_ACC: rd_byte = arith_primary_reg;
      core_sfr_pkg::IDX_AUX: rd_byte = mul_div_aux_reg;
      default:               rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= core_sfr_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      rresp  <= rd_ok ? core_sfr_pkg::RESP_OKAY : core_sfr_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  push_preinc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && op_code == core_sfr_pkg::OP_PUSH |=>
      stack_wr_en && stack_addr == $past(stack_top_pointer_reg) + 8'h01
      && stack_top_pointer_reg == stack_addr)
    else $error("push did not pre-increment stack pointer");

  pop_postdec_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && op_code == core_sfr_pkg::OP_POP |=>
      stack_rd_en && stack_addr == $past(stack_top_pointer_reg)
      && stack_top_pointer_reg == stack_addr - 8'h01)
    else $error("pop did not read before decrement");

  sp_reset_a: assert property (@(posedge aclk)
    !aresetn |=> stack_top_pointer_reg == core_sfr_pkg::RST_SP
      && arith_primary_reg == 8'h00)
    else $error("wrong reset value");

  muldiv_cy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && (op_code == core_sfr_pkg::OP_MUL
      || op_code == core_sfr_pkg::OP_DIV) |=> !carry_flag)
    else $error("carry not cleared by multiply or divide");

  mul_ov_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && op_code == core_sfr_pkg::OP_MUL |=>
      signed_overflow_flag == (mul_div_aux_reg != 8'h00))
    else $error("multiply overflow mismatch");

  div_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && op_code == core_sfr_pkg::OP_DIV && mul_div_aux_reg == 8'h00
      |=> signed_overflow_flag && $stable(arith_primary_reg))
    else $error("divide by zero not flagged");

  compare_jump_ne_op_cy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && op_code == core_sfr_pkg::OP_COMPARE_JUMP_NE_OP |=>
      carry_flag == ($past(op_cmp_a) < $past(op_src)))
    else $error("compare carry wrong");

  add_cy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && op_code == core_sfr_pkg::OP_ADD |=>
      {carry_flag, arith_primary_reg}
      == {1'b0, $past(arith_primary_reg)} + {1'b0, $past(op_src)})
    else $error("add carry wrong");

  parity_a: assert property (@(posedge aclk) disable iff (!aresetn)
    program_status_word[core_sfr_pkg::PSW_P] == ^arith_primary_reg)
    else $error("parity flag out of step");

  bank_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bank_base_addr == {program_status_word[4:3], 3'h0})
    else $error("bank base mismatch");

endmodule

`default_nettype wire

// ===== verification/cpu_core_sfr_file_bench.sv
// self-checking bench for the core special-function register file
`timescale 1ns/1ps
`default_nettype none

module cpu_core_sfr_file_bench;
  // ----------------------------------------------------------------
  // ports, clock and word addresses (index times four)
  // ----------------------------------------------------------------
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, op_valid;
  logic        stack_wr_en, stack_rd_en;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  op_src, op_cmp_a, stack_push_data, stack_addr, stack_wr_data;
  logic [7:0]  arith_primary_reg, mul_div_aux_reg, stack_top_pointer_reg;
  logic [7:0]  program_status_word;
  logic [15:0] data_ptr_16;
  logic [4:0]  bank_base_addr;
  core_sfr_pkg::core_op_e op_code;
  int          fails = 0;
  int          n_checks = 0;
  localparam logic [11:0] a_stk = 12'h204, a_dpl = 12'h208, a_dph = 12'h20c;
  localparam logic [11:0] a_stat = 12'h340, a_prim = 12'h380, a_aux = 12'h3c0;
  localparam logic [1:0]  ok = 2'h0, err = 2'h2;

  always #5 aclk = ~aclk;

  cpu_core_sfr_file uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .op_valid(op_valid),
    .op_code(op_code), .op_src(op_src), .op_cmp_a(op_cmp_a),
    .stack_push_data(stack_push_data), .stack_wr_en(stack_wr_en),
    .stack_rd_en(stack_rd_en), .stack_addr(stack_addr),
    .stack_wr_data(stack_wr_data), .arith_primary_reg(arith_primary_reg),
    .mul_div_aux_reg(mul_div_aux_reg),
    .stack_top_pointer_reg(stack_top_pointer_reg),
    .data_ptr_16(data_ptr_16), .program_status_word(program_status_word),
    .bank_base_addr(bank_base_addr)
  );

  // ----------------------------------------------------------------
  // report, compare and bus tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic hang;
    fails++;
    $display("ERROR %0t no answer from slave", $time);
    give_verdict();
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // an edge passes first so a strobe is never set twice in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] e);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (bvalid !== 1'b1) hang();
    chk(16'(bresp), 16'(e));
  endtask

  task automatic rdv(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] e);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (rvalid !== 1'b1) hang();
    chk(rdata[15:0], {8'h00, d});
    chk(16'(rresp), 16'(e));
  endtask

  // registers settle after the op edge; strobes are seen in their cycle
  task automatic op(input core_sfr_pkg::core_op_e c,
                    input logic [7:0] s = 8'h00, a = 8'h00, p = 8'h00);
    @(posedge aclk);
    op_valid <= 1'b1;
    op_code  <= c;
    op_src   <= s;
    op_cmp_a <= a;
    stack_push_data <= p;
    @(posedge aclk);
    op_valid <= 1'b0;
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdv(a_prim, 8'h00, ok);
    rdv(a_aux, 8'h00, ok);
    rdv(a_stk, 8'h07, ok);
    rdv(a_dpl, 8'h00, ok);
    rdv(a_stat, 8'h00, ok);
    chk(data_ptr_16, 16'h0000);
  endtask

  task automatic t_regs;
    wr(a_dpl, 8'h34, ok);
    wr(a_dph, 8'h12, ok);
    chk(data_ptr_16, 16'h1234);
    rdv(a_dph, 8'h12, ok);
    wr(a_aux, 8'h3c, ok);
    rdv(a_aux, 8'h3c, ok);
    wr(a_prim, 8'ha5, ok);
    chk(16'(program_status_word[0]), 16'h0000);
    wr(a_prim, 8'h07, ok);
    chk(16'(program_status_word[0]), 16'h0001);
    rdv(a_prim, 8'h07, ok);
    wr(12'h300, 8'h55, err);
    rdv(12'h300, 8'h00, err);
  endtask

  task automatic t_status;
    for (int b = 0; b < 4; b++) begin
      wr(a_stat, 8'(b << 3) | 8'h20, ok);
      chk(16'(bank_base_addr), 16'(b * 8));
      rdv(a_stat, 8'(b << 3) | 8'h21, ok);
    end
    wr(a_stat, 8'h02, ok);
    rdv(a_stat, 8'h03, ok);
  endtask

  task automatic t_add;
    wr(a_stat, 8'h24, ok);
    wr(a_prim, 8'h78, ok);
    op(core_sfr_pkg::OP_ADD, 8'h88);
    chk({arith_primary_reg, program_status_word}, 16'h00e0);
    wr(a_prim, 8'h40, ok);
    op(core_sfr_pkg::OP_ADD, 8'h40);
    chk({arith_primary_reg, program_status_word}, 16'h8025);
    wr(a_prim, 8'h00, ok);
    op(core_sfr_pkg::OP_SUBTRACT_BORROW_OP, 8'h01);
    chk({arith_primary_reg, program_status_word}, 16'hffe0);
    op(core_sfr_pkg::OP_ADD_CARRY_OP, 8'h00);
    chk({arith_primary_reg, program_status_word}, 16'h00e0);
  endtask

  task automatic t_muldiv;
    wr(a_stat, 8'h80, ok);
    wr(a_prim, 8'h20, ok);
    wr(a_aux, 8'h10, ok);
    op(core_sfr_pkg::OP_MUL);
    chk({mul_div_aux_reg, arith_primary_reg}, 16'h0200);
    chk(16'(program_status_word), 16'h0004);
    wr(a_stat, 8'h80, ok);
    wr(a_prim, 8'h64, ok);
    wr(a_aux, 8'h07, ok);
    op(core_sfr_pkg::OP_DIV);
    chk({mul_div_aux_reg, arith_primary_reg}, 16'h020e);
    chk(16'(program_status_word), 16'h0001);
    wr(a_stat, 8'h80, ok);
    wr(a_aux, 8'h00, ok);
    op(core_sfr_pkg::OP_DIV);
    chk(16'(program_status_word & 8'h84), 16'h0004);
  endtask

  task automatic t_misc;
    wr(a_stat, 8'h00, ok);
    wr(a_prim, 8'h99, ok);
    op(core_sfr_pkg::OP_ADD, 8'h01);
    op(core_sfr_pkg::OP_DA);
    chk({arith_primary_reg, 7'h00, program_status_word[7]}, 16'h0001);
    op(core_sfr_pkg::OP_COMPARE_JUMP_NE_OP, 8'h20, 8'h10);
    chk(16'(program_status_word[7]), 16'h0001);
    op(core_sfr_pkg::OP_COMPARE_JUMP_NE_OP, 8'h20, 8'h30);
    chk(16'(program_status_word[7]), 16'h0000);
    op(core_sfr_pkg::OP_PUSH, 8'h00, 8'h00, 8'h5a);
    chk({stack_top_pointer_reg, stack_addr}, 16'h0808);
    chk({7'h00, stack_wr_en, stack_wr_data}, 16'h015a);
    op(core_sfr_pkg::OP_POP);
    chk({stack_top_pointer_reg, stack_addr}, 16'h0708);
    chk(16'(stack_rd_en), 16'h0001);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, op_valid} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {op_src, op_cmp_a, stack_push_data} = '0;
    op_code = core_sfr_pkg::OP_ADD;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_regs();
    t_status();
    t_add();
    t_muldiv();
    t_misc();
    give_verdict();
  end
endmodule

`default_nettype wire
